// ---- core/ccu_capture_compare_unit.sv ----
// Implementation choice: register access over APB.
`timescale 1ns/100ps
// Summary of operation
// - capture copies full timer count into value
// - mode picks falling, rising, 4th, 16th edge
// - mode zero disables and resets internal state
// - compare set/clear modes drive pin, flag
// - software-interrupt compare only sets the flag
// - trigger compare resets timer, starts conversion
// - constant compare; pin action and flag together
// - capture sets sticky flag until software clears
// - new capture overwrites unread held value
// - prescaler cleared when off or not capturing
// - capture-to-capture mode change keeps prescaler
// - clear-to-set via low bit inverts output
// - pin level observed even when driven
// - control bits 5-4 stored, ignored here
// - value bytes separate; control 7-6 read zero
// - trigger reset never sets timer overflow flag
// - timer write beats simultaneous trigger reset
// - clearing control forces compare latch low
module ccu_capture_compare_unit (
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic        cc_pin_i,
   output logic             cc_pin_o,
   output logic             cc_pin_oe_o,
   input  wire logic        adc_enable_i,
   output logic             adc_start_o
);
   ccu_pkg::ccu_state_type s_q;
   ccu_pkg::ccu_state_type s_d;
   logic                   pin_rise;
   logic                   pin_fall;
   logic [3:0]             mode;
   logic                   cap_mode;
   logic                   cmp_mode;
   logic                   match;
   logic                   trig;
   logic                   cap_ev;
   logic                   capture;
   logic [7:0]             idx;
   logic                   wr_en;
   logic                   tmr_wr;
   logic [7:0]             wd;
   logic [16:0]            tmr_inc;

   // pin seen at its level whatever the direction bit says
   ccu_pin_sync u_sync (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .pin_i      (cc_pin_i),
      .rise_o     (pin_rise),
      .fall_o     (pin_fall)
   );

   // decode of mode and events from present state
   always_comb begin
      mode     = s_q.ctl[3:0];
      cap_mode = mode[3:2] == ccu_pkg::GRP_CAP;
      cmp_mode = mode[3:2] == ccu_pkg::GRP_CMP;
      match    = cmp_mode && (s_q.tmr == s_q.val);
      trig     = match && (mode == ccu_pkg::CMP_TRIG);
      case (mode)
         ccu_pkg::CAP_FALL: cap_ev = pin_fall;
         ccu_pkg::CAP_RISE: cap_ev = pin_rise;
         ccu_pkg::CAP_4TH:  cap_ev = pin_rise && (s_q.psc[1:0] == ccu_pkg::PSC_4_LAST);
         ccu_pkg::CAP_16TH: cap_ev = pin_rise && (s_q.psc == ccu_pkg::PSC_16_LAST);
         default:           cap_ev = 1'b0;
      endcase
      capture = cap_mode && cap_ev;
      idx     = paddr_i[9:2];
      wd      = pwdata_i[7:0];
      // a write lands at the edge where the master sees pready
      wr_en   = psel_i && penable_i && pwrite_i && s_q.pready;
      tmr_wr  = wr_en && (idx == ccu_pkg::IDX_TMR_LO || idx == ccu_pkg::IDX_TMR_HI);
      tmr_inc = {1'b0, s_q.tmr} + 17'h00001;
   end

   // next state: software writes first, hardware events over them, except that a timer write beats trigger reset and count, and mode zero clears the latch last
   always_comb begin
      s_d        = s_q;
      s_d.adc    = trig && adc_enable_i;
      // one wait state so read data come from a flop
      s_d.pready = psel_i && penable_i && !s_q.pready;
      if (psel_i && penable_i && !s_q.pready) begin
         s_d.slverr = 1'b0;
         case (idx)
            ccu_pkg::IDX_PORT:    s_d.rdata = s_q.port;
            ccu_pkg::IDX_FLAGS:   s_d.rdata = {5'h00, s_q.ccf, 1'b0, s_q.tof};
            ccu_pkg::IDX_TMR_LO:  s_d.rdata = s_q.tmr[7:0];
            ccu_pkg::IDX_TMR_HI:  s_d.rdata = s_q.tmr[15:8];
            ccu_pkg::IDX_TMR_CTL: s_d.rdata = {7'h00, s_q.tmr_on};
            ccu_pkg::IDX_VAL_LO:  s_d.rdata = s_q.val[7:0];
            ccu_pkg::IDX_VAL_HI:  s_d.rdata = s_q.val[15:8];
            ccu_pkg::IDX_CTL:     s_d.rdata = {2'h0, s_q.ctl};
            ccu_pkg::IDX_DIR:     s_d.rdata = s_q.dir;
            ccu_pkg::IDX_IE:      s_d.rdata = s_q.ie;
            default: begin
               s_d.rdata  = 8'h00;
               s_d.slverr = 1'b1;
            end
         endcase
      end
      if (wr_en) begin
         case (idx)
            ccu_pkg::IDX_PORT:    s_d.port = wd;
            ccu_pkg::IDX_FLAGS: begin
               s_d.ccf = wd[ccu_pkg::FLAG_CC_BIT];
               s_d.tof = wd[ccu_pkg::FLAG_TOF_BIT];
            end
            ccu_pkg::IDX_TMR_CTL: s_d.tmr_on = wd[ccu_pkg::TMR_ON_BIT];
            ccu_pkg::IDX_VAL_LO:  s_d.val[7:0] = wd;
            ccu_pkg::IDX_VAL_HI:  s_d.val[15:8] = wd;
            ccu_pkg::IDX_CTL: begin
               s_d.ctl = wd[5:0];
               // dropping only the low bit from clear-mode flips the output
               if (mode == ccu_pkg::CMP_CLR && wd[3:0] == ccu_pkg::CMP_SET) begin
                  s_d.inv = 1'b1;
               end
            end
            ccu_pkg::IDX_DIR:     s_d.dir = wd;
            ccu_pkg::IDX_IE:      s_d.ie = wd;
            default:              s_d.ie = s_q.ie;
         endcase
      end
      // timer: software write wins, then trigger reset, then count
      if (tmr_wr) begin
         if (idx == ccu_pkg::IDX_TMR_LO) begin
            s_d.tmr[7:0] = wd;
         end else begin
            s_d.tmr[15:8] = wd;
         end
      end else if (trig) begin
         s_d.tmr = 16'h0000;
      end else if (s_q.tmr_on) begin
         s_d.tmr = tmr_inc[15:0];
         if (tmr_inc[16]) begin
            s_d.tof = 1'b1;
         end
      end
      // capture overwrites even an unread value and any byte write
      if (capture) begin
         s_d.val = s_q.tmr;
      end
      // flag set beats a software clear in the same cycle
      if (capture || match) begin
         s_d.ccf = 1'b1;
      end
      if (match && mode == ccu_pkg::CMP_SET) begin
         s_d.latch = 1'b1;
      end else if (match && mode == ccu_pkg::CMP_CLR) begin
         s_d.latch = 1'b0;
      end
      // prescaler counts rising edges; a direct capture mode change keeps it
      if (s_d.ctl[3:2] != ccu_pkg::GRP_CAP) begin
         s_d.psc = 4'h0;
      end else if (cap_mode && pin_rise) begin
         s_d.psc = s_q.psc + 4'h1;
      end
      // mode zero is the unit reset
      if (s_d.ctl[3:0] == ccu_pkg::MODE_OFF) begin
         s_d.latch = 1'b0;
         s_d.inv   = 1'b0;
      end
      // compare modes own the pin, otherwise the port latch drives it
      if (s_d.ctl[3:2] == ccu_pkg::GRP_CMP) begin
         s_d.pin = s_d.latch ^ s_d.inv;
      end else begin
         s_d.pin = s_d.port[ccu_pkg::PIN_BIT];
      end
      s_d.oe = ~s_d.dir[ccu_pkg::PIN_BIT];
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_q <= ccu_pkg::STATE_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // all outputs straight from the state flops
   assign prdata_o    = {24'h000000, s_q.rdata};
   assign pready_o    = s_q.pready;
   assign pslverr_o   = s_q.slverr;
   assign cc_pin_o    = s_q.pin;
   assign cc_pin_oe_o = s_q.oe;
   assign adc_start_o = s_q.adc;

   // checks on the block's own behaviour
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);

   capture_flag_a: assert property (capture |=> s_q.ccf)
      else $error("capture did not set event flag");
   capture_value_a: assert property (capture |=> s_q.val == $past(s_q.tmr))
      else $error("captured value differs from timer");
   cmp_high_a: assert property ((match && mode == ccu_pkg::CMP_SET && !wr_en)
      |=> s_q.latch && s_q.ccf)
      else $error("set-on-match did not raise latch");
   cmp_low_a: assert property ((match && mode == ccu_pkg::CMP_CLR && !wr_en)
      |=> !s_q.latch && s_q.ccf)
      else $error("clear-on-match did not drop latch");
   sw_pin_a: assert property ((match && mode == ccu_pkg::CMP_SW && !wr_en)
      |=> s_q.latch == $past(s_q.latch) && s_q.ccf)
      else $error("software compare touched latch");
   trig_timer_a: assert property ((trig && !tmr_wr) |=> s_q.tmr == 16'h0000)
      else $error("trigger did not reset timer");
   trig_tof_a: assert property ((trig && !wr_en) |=> s_q.tof == $past(s_q.tof))
      else $error("trigger reset set overflow flag");
   trig_adc_a: assert property ((trig && adc_enable_i) |=> adc_start_o ##1 1'b1)
      else $error("trigger did not start conversion");
   off_clear_a: assert property ((s_q.ctl[3:0] == ccu_pkg::MODE_OFF)
      |-> s_q.psc == 4'h0 && !s_q.latch && !s_q.inv)
      else $error("disabled unit kept internal state");
   psc_clear_a: assert property ((s_q.ctl[3:2] != ccu_pkg::GRP_CAP) |-> s_q.psc == 4'h0)
      else $error("prescaler not cleared outside capture");
   invert_hold_a: assert property ((s_q.inv && s_q.ctl[3:0] != ccu_pkg::MODE_OFF)
      |=> s_q.inv || s_q.ctl[3:0] == ccu_pkg::MODE_OFF)
      else $error("output inversion lost");
   wr_wins_a: assert property ((trig && tmr_wr && idx == ccu_pkg::IDX_TMR_LO)
      |=> s_q.tmr[7:0] == $past(wd))
      else $error("trigger overrode timer write");

   // flag only falls through a software write
   flag_hold_a: assert property (s_q.ccf
      && !(wr_en && idx == ccu_pkg::IDX_FLAGS) |=> s_q.ccf)
      else $error("event flag dropped without a clear");

   // a software zero clears the flag when no event competes
   flag_clear_a: assert property (wr_en && idx == ccu_pkg::IDX_FLAGS
      && !wd[ccu_pkg::FLAG_CC_BIT] && !capture && !match |=> !s_q.ccf)
      else $error("software clear of event flag lost");

   // a direct capture-to-capture change keeps the prescale count
   psc_keep_a: assert property (cap_mode && wr_en && idx == ccu_pkg::IDX_CTL
      && wd[3:2] == ccu_pkg::GRP_CAP && !pin_rise |=> s_q.psc == $past(s_q.psc))
      else $error("prescaler cleared by direct mode change");

   // every rising edge in a capture mode advances the prescaler, unless a control write leaves capture in that cycle
   psc_count_a: assert property (cap_mode && pin_rise
      && !(wr_en && idx == ccu_pkg::IDX_CTL) |=> s_q.psc == $past(s_q.psc) + 4'h1)
      else $error("prescaler missed a rising edge");

   // leaving capture clears the prescaler at once
   psc_leave_a: assert property (wr_en && idx == ccu_pkg::IDX_CTL
      && wd[3:2] != ccu_pkg::GRP_CAP |=> s_q.psc == 4'h0)
      else $error("prescaler kept after leaving capture");

   // control reads show bits 7-6 as zero
   ctl_read_a: assert property (psel_i && penable_i && !s_q.pready
      && idx == ccu_pkg::IDX_CTL |=> prdata_o[7:6] == 2'h0)
      else $error("control read showed upper bits");

   // value high byte reads back on its own
   val_read_a: assert property (psel_i && penable_i && !s_q.pready
      && idx == ccu_pkg::IDX_VAL_HI |=> prdata_o[7:0] == $past(s_q.val[15:8]))
      else $error("value high byte read wrong");

   // clearing control drops the compare latch, not the port latch
   ctl_clear_a: assert property (wr_en && idx == ccu_pkg::IDX_CTL
      && wd[3:0] == ccu_pkg::MODE_OFF |=> !s_q.latch && s_q.port == $past(s_q.port))
      else $error("control clear left compare latch set");

   // no conversion start without an enabled trigger
   no_adc_a: assert property (!(trig && adc_enable_i) |=> !adc_start_o)
      else $error("conversion start without trigger");

   // only the trigger mode resets a stopped timer on a match
   timer_keep_a: assert property (match && mode != ccu_pkg::CMP_TRIG
      && !tmr_wr && !s_q.tmr_on |=> s_q.tmr == $past(s_q.tmr))
      else $error("timer moved on a plain compare match");

   // value register moves only by capture or a byte write
   val_keep_a: assert property (!capture && !(wr_en
      && (idx == ccu_pkg::IDX_VAL_LO || idx == ccu_pkg::IDX_VAL_HI)) |=> $stable(s_q.val))
      else $error("value register changed by itself");

   // a plain rollover does set the overflow flag, unlike the trigger
   tof_set_a: assert property (s_q.tmr_on && s_q.tmr == 16'hFFFF
      && !tmr_wr && !trig |=> s_q.tof)
      else $error("timer rollover missed overflow flag");

   // clear-to-set via the low mode bit turns inversion on
   invert_set_a: assert property (wr_en && idx == ccu_pkg::IDX_CTL
      && mode == ccu_pkg::CMP_CLR && wd[3:0] == ccu_pkg::CMP_SET |=> s_q.inv)
      else $error("inversion not set by clear-to-set change");

   // outside a match or a control write the compare latch holds
   latch_hold_a: assert property (!match && !(wr_en && idx == ccu_pkg::IDX_CTL)
      |=> s_q.latch == $past(s_q.latch))
      else $error("compare latch moved without a match");

   // the synchroniser yields one rise pulse per edge
   rise_once_a: assert property (pin_rise |=> !pin_rise)
      else $error("one pin edge gave two rise pulses");
endmodule

// ---- core/ccu_pkg.sv ----
package ccu_pkg;
   // register indexes; byte address is four times the index
   localparam logic [7:0]  IDX_PORT     = 8'h07;
   localparam logic [7:0]  IDX_FLAGS    = 8'h0C;
   localparam logic [7:0]  IDX_TMR_LO   = 8'h0E;
   localparam logic [7:0]  IDX_TMR_HI   = 8'h0F;
   localparam logic [7:0]  IDX_TMR_CTL  = 8'h10;
   localparam logic [7:0]  IDX_VAL_LO   = 8'h15;
   localparam logic [7:0]  IDX_VAL_HI   = 8'h16;
   localparam logic [7:0]  IDX_CTL      = 8'h17;
   localparam logic [7:0]  IDX_DIR      = 8'h87;
   localparam logic [7:0]  IDX_IE       = 8'h8C;
   // mode select codes
   localparam logic [3:0]  MODE_OFF     = 4'h0;
   localparam logic [3:0]  CAP_FALL     = 4'h4;
   localparam logic [3:0]  CAP_RISE     = 4'h5;
   localparam logic [3:0]  CAP_4TH      = 4'h6;
   localparam logic [3:0]  CAP_16TH     = 4'h7;
   localparam logic [3:0]  CMP_SET      = 4'h8;
   localparam logic [3:0]  CMP_CLR      = 4'h9;
   localparam logic [3:0]  CMP_SW       = 4'hA;
   localparam logic [3:0]  CMP_TRIG     = 4'hB;
   localparam logic [1:0]  GRP_CAP      = 2'h1;
   localparam logic [1:0]  GRP_CMP      = 2'h2;
   // field positions and prescaler terminal counts
   localparam int          FLAG_CC_BIT  = 2;
   localparam int          FLAG_TOF_BIT = 0;
   localparam int          PIN_BIT      = 2;
   localparam int          TMR_ON_BIT   = 0;
   localparam logic [1:0]  PSC_4_LAST   = 2'h3;
   localparam logic [3:0]  PSC_16_LAST  = 4'hF;
   localparam logic [7:0]  DIR_RESET    = 8'hFF;

   typedef struct packed {
      logic [5:0]  ctl;
      logic [15:0] val;
      logic [15:0] tmr;
      logic        tmr_on;
      logic        ccf;
      logic        tof;
      logic [7:0]  ie;
      logic [7:0]  port;
      logic [7:0]  dir;
      logic [3:0]  psc;
      logic        latch;
      logic        inv;
      logic        adc;
      logic        pin;
      logic        oe;
      logic        pready;
      logic        slverr;
      logic [7:0]  rdata;
   } ccu_state_type;

   localparam ccu_state_type STATE_RESET = '{
      ctl: 6'h00, val: 16'h0000, tmr: 16'h0000, tmr_on: 1'b0, ccf: 1'b0, tof: 1'b0,
      ie: 8'h00, port: 8'h00, dir: DIR_RESET, psc: 4'h0, latch: 1'b0, inv: 1'b0,
      adc: 1'b0, pin: 1'b0, oe: 1'b0, pready: 1'b0, slverr: 1'b0, rdata: 8'h00};

   typedef struct packed {
      logic meta;
      logic sync;
      logic prev;
   } ccu_sync_type;
endpackage

// ---- core/ccu_pin_sync.sv ----
`timescale 1ns/100ps
module ccu_pin_sync (
   input  wire logic core_clk_i,
   input  wire logic rst_i,
   input  wire logic pin_i,
   output logic      rise_o,
   output logic      fall_o
);
   ccu_pkg::ccu_sync_type s_q;
   ccu_pkg::ccu_sync_type s_d;

   // meta feeds only sync; edges look at sync and prev
   always_comb begin
      s_d      = s_q;
      s_d.meta = pin_i;
      s_d.sync = s_q.meta;
      s_d.prev = s_q.sync;
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // one pulse per settled edge
   assign rise_o = s_q.sync & ~s_q.prev;
   assign fall_o = ~s_q.sync & s_q.prev;
endmodule

// ---- tb/ccu_pin_model.sv ----
`timescale 1ns/100ps
// outside source on the capture pin
module ccu_pin_model (
   input  wire logic level_i,
   input  wire logic drv_i,
   input  wire logic oe_i,
   output logic      pin_o
);
   // our drive wins while enabled, so port writes can still reach capture
   assign pin_o = oe_i ? drv_i : level_i;
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        pen = 1'b0;
   logic        pwr = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic        pready, pslverr, pin_in, pin_drv, pin_oe, adc_st;
   logic        level = 1'b0;
   logic        adc_en = 1'b1;
   logic [7:0]  rv;
   logic        er;
   logic [15:0] t, v;
   logic [3:0]  cm [6] = '{4'h8, 4'hA, 4'h9, 4'h8, 4'h0, 4'h8};
   logic        cp [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
   int          bad_count = 0;
   int          tests_run = 0;
   int          cyc = 0;
   int          n;
   int          seed = 32'hE2B6;

   // 25 MHz core clock
   always #20 clk = ~clk;

   ccu_capture_compare_unit dut (.core_clk_i(clk), .rst_i(rst), .psel_i(psel),
      .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .cc_pin_i(pin_in),
      .cc_pin_o(pin_drv), .cc_pin_oe_o(pin_oe), .adc_enable_i(adc_en),
      .adc_start_o(adc_st));
   ccu_pin_model pm (.level_i(level), .drv_i(pin_drv), .oe_i(pin_oe), .pin_o(pin_in));

   task automatic close_out();
      if (bad_count == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // hang guard, well above the expected run length
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         bad_count++;
         close_out();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // one apb transfer; request held until pready is sampled high
   task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d,
                       output logic [7:0] r, output logic e);
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h000000, d};
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata[7:0];
      e = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] r;
      logic       e;
      xfer(1'b1, idx, d, r, e);
   endtask

   task automatic rd(input logic [7:0] idx, output logic [7:0] r);
      logic e;
      xfer(1'b0, idx, 8'h00, r, e);
   endtask

   task automatic settmr(input logic [15:0] x);
      wr(ccu_pkg::IDX_TMR_LO, x[7:0]);
      wr(ccu_pkg::IDX_TMR_HI, x[15:8]);
   endtask

   task automatic rdval(output logic [15:0] x);
      rd(ccu_pkg::IDX_VAL_LO, x[7:0]);
      rd(ccu_pkg::IDX_VAL_HI, x[15:8]);
   endtask

   // one full pin cycle: a rise, then a fall
   task automatic pulse();
      level <= 1'b1;
      repeat (5) @(posedge clk);
      level <= 1'b0;
      repeat (5) @(posedge clk);
   endtask

   function automatic int edges_for(input logic [3:0] m);
      return (m == ccu_pkg::CAP_4TH) ? 4 : (m == ccu_pkg::CAP_16TH) ? 16 : 1;
   endfunction

   // main sequence
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rd(ccu_pkg::IDX_CTL, rv);
      chk(rv, 8'h00, "ctl reset");
      xfer(1'b1, 8'h01, 8'h5A, rv, er);
      chk(er, 1'b1, "unmapped not refused");
      wr(ccu_pkg::IDX_CTL, 8'hFF);
      rd(ccu_pkg::IDX_CTL, rv);
      chk(rv, 8'h3F, "ctl readback");
      wr(ccu_pkg::IDX_VAL_LO, 8'h5A);
      wr(ccu_pkg::IDX_VAL_HI, 8'hA5);
      rdval(v);
      chk(v, 16'hA55A, "value bytes");
      // each capture mode, prescaler cleared by going through off
      for (int m = 4; m < 8; m++) begin
         t = 16'($random(seed));
         wr(ccu_pkg::IDX_CTL, 8'h00);
         settmr(t);
         wr(ccu_pkg::IDX_CTL, 8'(m));
         wr(ccu_pkg::IDX_FLAGS, 8'h00);
         repeat (edges_for(4'(m)) - 1) pulse();
         rd(ccu_pkg::IDX_FLAGS, rv);
         chk(rv[2], 1'b0, "early capture");
         pulse();
         rd(ccu_pkg::IDX_FLAGS, rv);
         chk(rv[2], 1'b1, "no capture flag");
         rdval(v);
         chk(v, t, "captured value");
      end
      // direct prescale change keeps the count, so the capture comes early
      wr(ccu_pkg::IDX_CTL, 8'h00);
      wr(ccu_pkg::IDX_CTL, {4'h0, ccu_pkg::CAP_4TH});
      repeat (2) pulse();
      wr(ccu_pkg::IDX_CTL, {4'h0, ccu_pkg::CAP_16TH});
      wr(ccu_pkg::IDX_FLAGS, 8'h00);
      repeat (13) pulse();
      rd(ccu_pkg::IDX_FLAGS, rv);
      chk(rv[2], 1'b0, "early direct change");
      pulse();
      rd(ccu_pkg::IDX_FLAGS, rv);
      chk(rv[2], 1'b1, "prescaler cleared by change");
      // unread value overwritten by a later capture
      wr(ccu_pkg::IDX_CTL, 8'h00);
      wr(ccu_pkg::IDX_CTL, {4'h0, ccu_pkg::CAP_RISE});
      settmr(16'($random(seed)));
      pulse();
      t = 16'($random(seed));
      settmr(t);
      pulse();
      rdval(v);
      chk(v, t, "overwrite");
      // pin as output: a port write makes the capture edge
      t = 16'($random(seed));
      settmr(t);
      wr(ccu_pkg::IDX_DIR, 8'hFB);
      wr(ccu_pkg::IDX_PORT, 8'h04);
      repeat (5) @(posedge clk);
      chk(pin_oe, 1'b1, "pin not driven");
      rdval(v);
      chk(v, t, "port write capture");
      wr(ccu_pkg::IDX_DIR, 8'hFF);
      wr(ccu_pkg::IDX_PORT, 8'h00);
      // compare with the timer held on the match value
      t = 16'($random(seed)) | 16'h0100;
      wr(ccu_pkg::IDX_CTL, 8'h00);
      settmr(t);
      wr(ccu_pkg::IDX_VAL_LO, t[7:0]);
      wr(ccu_pkg::IDX_VAL_HI, t[15:8]);
      for (int i = 0; i < 6; i++) begin
         wr(ccu_pkg::IDX_CTL, {4'h0, cm[i]});
         repeat (3) @(posedge clk);
         chk(pin_drv, cp[i], "compare pin");
         wr(ccu_pkg::IDX_FLAGS, 8'h00);
         rd(ccu_pkg::IDX_FLAGS, rv);
         chk(rv[2], cm[i] != 4'h0, "compare flag");
      end
      // trigger mode: timer cleared, one conversion start, no overflow flag
      wr(ccu_pkg::IDX_FLAGS, 8'h00);
      wr(ccu_pkg::IDX_CTL, {4'h0, ccu_pkg::CMP_TRIG});
      n = 0;
      repeat (12) begin
         @(posedge clk);
         if (adc_st === 1'b1) n++;
      end
      chk(16'(n), 16'h0001, "conversion starts");
      rd(ccu_pkg::IDX_TMR_HI, v[15:8]);
      rd(ccu_pkg::IDX_TMR_LO, v[7:0]);
      chk(v, 16'h0000, "timer not cleared");
      rd(ccu_pkg::IDX_FLAGS, rv);
      chk({rv[2], rv[0]}, 2'b10, "trigger flags");
      // running timer: a plain rollover raises the overflow flag
      wr(ccu_pkg::IDX_CTL, 8'h00);
      settmr(16'hFFF0);
      wr(ccu_pkg::IDX_TMR_CTL, 8'h01);
      repeat (24) @(posedge clk);
      wr(ccu_pkg::IDX_TMR_CTL, 8'h00);
      rd(ccu_pkg::IDX_FLAGS, rv);
      chk(rv[0], 1'b1, "rollover flag");
      // converter disabled: trigger clears timer and sets the event flag, no start
      settmr(t);
      wr(ccu_pkg::IDX_FLAGS, 8'h00);
      adc_en <= 1'b0;
      wr(ccu_pkg::IDX_CTL, {4'h0, ccu_pkg::CMP_TRIG});
      n = 0;
      repeat (12) begin
         @(posedge clk);
         if (adc_st === 1'b1) n++;
      end
      chk(16'(n), 16'h0000, "start while disabled");
      rd(ccu_pkg::IDX_TMR_HI, v[15:8]);
      rd(ccu_pkg::IDX_TMR_LO, v[7:0]);
      chk(v, 16'h0000, "timer kept");
      rd(ccu_pkg::IDX_FLAGS, rv);
      chk({rv[2], rv[0]}, 2'b10, "disabled trigger flags");
      close_out();
   end
endmodule
